// >>> exec_core.sv
`timescale 1ns/1ns
module exec_core
  import exec_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        instr_valid_in,
  input  wire logic [15:0] instr_in,
  input  wire logic        next_two_word_in,
  input  wire logic        ext_set_in,
  input  wire logic [3:0]  bank_select_register_in,
  input  wire logic [11:0] index_base_in,
  input  wire logic [7:0]  table_data_latch_in,
  input  wire logic [7:0]  file_data_in,
  input  wire logic        ptr_load_in,
  input  wire logic [20:0] ptr_load_val_in,
  input  wire logic        w_load_in,
  input  wire logic [7:0]  w_load_val_in,
  output logic             busy_out,
  output logic             discard_out,
  output logic [11:0]      file_addr_out,
  output logic             file_read_out,
  output logic [20:0]      program_byte_pointer_out,
  output logic [7:0]       holding_data_out,
  output logic [20:0]      holding_addr_out,
  output logic             holding_write_out,
  output logic [7:0]       w_out,
  output logic             neg_flag_out,
  output logic             zero_flag_out
);
  // Sequencer state and the context of the instruction that owns it
  cyc_state_t  state_r;
  cyc_state_t  state_nxt;
  logic [1:0]  mode_r;
  logic        skip_two_r;
  logic        tw_own_r;

  // Working register and its flags
  logic [7:0]  w_r;
  logic        neg_r;
  logic        zero_r;

  // Holding register copy and its write strobe
  logic [7:0]  hold_data_r;
  logic [20:0] hold_addr_r;
  logic        hold_wr_r;

  // Operand address registered every cycle, shown for the one cycle after the word is taken
  logic [11:0] faddr_r;
  logic        fread_r;

  // Pointer unit link
  ptr_if       ptr ();

  // Cycle phase decode, shared by sequencing, pointer and holding logic
  wire         in_decode    = (state_r == ST_DECODE);
  wire         in_second    = (state_r == ST_SECOND);
  wire         in_third     = (state_r == ST_THIRD);
  // Second cycle of a table write is the only one that touches the holding register
  wire         tw_capture   = in_second && tw_own_r;
  // Post modes step after the store; no-change and pre-increment never do here
  wire         post_mode    = (mode_r == TW_POSTINC) || (mode_r == TW_POSTDEC);

  // Instruction decode
  // Only one of the three kinds can match a word; the masks do not overlap
  wire         accept       = instr_valid_in && in_decode;
  wire         is_tblwr     = accept && ((instr_in & TBLWR_MASK) == TBLWR_BASE);
  wire         is_tstz      = accept && ((instr_in & TSTZ_MASK) == TSTZ_BASE);
  wire         is_xorl      = accept && ((instr_in & XORL_MASK) == XORL_BASE);
  wire [1:0]   tw_mode      = instr_in[TW_MODE_LSB +: 2];
  wire [7:0]   f_field      = instr_in[7:0];
  wire         acc_bit      = instr_in[ACC_BIT];
  wire [7:0]   xor_res      = w_r ^ instr_in[7:0];

  // Operand address resolution
  // Access bank: low half from bank 0, high half from bank 15
  // Indexed address wraps at 12 bits, so a large base folds back to the bottom
  // indexed literal offset
  wire         use_index    = !acc_bit && ext_set_in && (f_field <= IDX_LIMIT);
  wire [3:0]   acc_bank     = (f_field < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
  wire [3:0]   bank         = acc_bit ? bank_select_register_in : acc_bank;
  wire [11:0]  direct_addr  = {bank, f_field};
  wire [11:0]  index_addr   = index_base_in + {4'h0, f_field};
  wire [11:0]  opnd_addr    = use_index ? index_addr : direct_addr;

  // Zero test needs the operand read this cycle; the data bus answers combinationally
  // A nonzero operand leaves the sequencer in decode, so the next word runs at once
  // skip on zero
  wire         skip         = is_tstz && (file_data_in == BYTE_RST);

  // Pointer steps: pre-increment in decode, post steps in the second cycle
  // Pre-increment steps in decode so the second cycle already sees the new address
  // The pointer unit gets at most one step request per cycle
  // pre-increment
  wire         pre_step     = is_tblwr && (tw_mode == TW_PREINC);
  // post-increment, post-decrement, no-change holds pointer
  // Stepping at the end of the second cycle keeps the stored address pre-step
  wire         post_step    = tw_capture && post_mode;
  assign ptr.step = pre_step || post_step;
  assign ptr.down = post_step && (mode_r == TW_POSTDEC);

  ptr_unit u_ptr (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (ptr_load_in),
    .load_val_in (ptr_load_val_in),
    .port        (ptr.unit)
  );

  // Cycle plan per instruction, one clock per instruction cycle:
  //   xor literal   - decode only, W and flags written at its end
  //   table write   - decode, then one cycle that moves latch to holding
  //   skip taken    - decode, then one nop, or two over a two-word instruction
  //   skip not made - decode only; the prefetched word runs next
  // An unknown opcode is taken and dropped in one cycle, so the core never stalls on it
  // Cycle sequencing
  // three cycles on two-word skip, two cycles for table write
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DECODE: state_nxt = (is_tblwr || skip) ? ST_SECOND : ST_DECODE;
      ST_SECOND: state_nxt = skip_two_r ? ST_THIRD : ST_DECODE;
      ST_THIRD:  state_nxt = ST_DECODE;
      default:   state_nxt = ST_DECODE;
    endcase
  end

  // State and instruction context
  // Context is captured only on accept so it survives the extra cycles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= ST_DECODE;
      mode_r     <= TW_NOCHG;
      skip_two_r <= 1'b0;
      tw_own_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        mode_r     <= tw_mode;
        skip_two_r <= skip && next_two_word_in;
        tw_own_r   <= is_tblwr;
      end
    end
  end

  // Holding register write in the second cycle, using the pointer as it then stands
  // latch to holding
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_data_r <= BYTE_RST;
      hold_addr_r <= PTR_RST;
      hold_wr_r   <= 1'b0;
    end else begin
      hold_wr_r <= tw_capture;
      if (tw_capture) begin
        hold_data_r <= table_data_latch_in;
        hold_addr_r <= ptr.value;
      end
    end
  end

  // Working register and flags
  // Xor outranks a load of W in the same cycle; the load is then lost
  // xor literal
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_r    <= BYTE_RST;
      neg_r  <= 1'b0;
      zero_r <= 1'b0;
    end else if (is_xorl) begin
      w_r    <= xor_res;
      neg_r  <= xor_res[7];
      zero_r <= (xor_res == BYTE_RST);
    end else if (w_load_in) begin
      w_r <= w_load_val_in;
    end
  end

  // Registered operand address for the data memory
  // Copy reloads every cycle, so the address stays visible for one cycle after the word has gone
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      faddr_r <= ADDR_RST;
      fread_r <= 1'b0;
    end else begin
      faddr_r <= opnd_addr;
      fread_r <= is_tstz;
    end
  end

  // Sequencer status; a table write's extra cycle is busy but not a discard
  assign busy_out                 = in_second || in_third;
  assign discard_out              = (in_second || in_third) && !tw_own_r;

  // Operand access; the file address is also shown combinationally for timing
  assign file_addr_out            = accept ? opnd_addr : faddr_r;
  assign file_read_out            = is_tstz || fread_r;

  // Pointer and holding register
  assign program_byte_pointer_out = ptr.value;
  assign holding_data_out         = hold_data_r;
  assign holding_addr_out         = hold_addr_r;
  assign holding_write_out        = hold_wr_r;

  // Working register and flags
  assign w_out                    = w_r;
  assign neg_flag_out             = neg_r;
  assign zero_flag_out            = zero_r;
endmodule // exec_core

// >>> exec_pkg.sv
package exec_pkg;
  // Opcode patterns, 16-bit instruction words
  localparam logic [15:0] TBLWR_BASE    = 16'h000C;
  localparam logic [15:0] TBLWR_MASK    = 16'hFFFC;
  localparam logic [15:0] TSTZ_BASE     = 16'h6600;
  localparam logic [15:0] TSTZ_MASK     = 16'hFE00;
  localparam logic [15:0] XORL_BASE     = 16'h0A00;
  localparam logic [15:0] XORL_MASK     = 16'hFF00;
  // Field positions
  localparam int          ACC_BIT       = 8;
  localparam int          TW_MODE_LSB   = 0;
  // Table-write pointer modes
  localparam logic [1:0]  TW_NOCHG      = 2'h0;
  localparam logic [1:0]  TW_POSTINC    = 2'h1;
  localparam logic [1:0]  TW_POSTDEC    = 2'h2;
  localparam logic [1:0]  TW_PREINC     = 2'h3;
  // Indexed literal offset threshold (95)
  localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
  // Access bank split: low half in bank 0, high half in bank 15
  localparam logic [7:0]  ACC_SPLIT     = 8'h80;
  localparam logic [3:0]  ACC_HI_BANK   = 4'hF;
  localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
  // Reset values
  localparam logic [20:0] PTR_RST       = 21'h00_0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [11:0] ADDR_RST      = 12'h000;
  // Widths
  localparam int          PTR_W         = 21;
  // Cycle states, Gray ordered along the usual path
  typedef enum logic [1:0] {
    ST_DECODE = 2'b00,
    ST_SECOND = 2'b01,
    ST_THIRD  = 2'b11
  } cyc_state_t;
endpackage

// >>> ptr_if.sv
`timescale 1ns/1ns
// Pointer update request between core and pointer unit
interface ptr_if;
  logic       step;
  logic       down;
  logic [20:0] value;
  modport core (output step, output down, input value);
  modport unit (input step, input down, output value);
endinterface // ptr_if

// >>> ptr_unit.sv
`timescale 1ns/1ns
module ptr_unit
  import exec_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        load_in,
  input  wire logic [20:0] load_val_in,
  ptr_if.unit              port
);
  logic [20:0] ptr_r;
  logic [20:0] ptr_nxt;
  // Software load has priority over a step from an instruction
  assign ptr_nxt = load_in   ? load_val_in :
                   port.step ? (port.down ? ptr_r - 21'h00_0001 : ptr_r + 21'h00_0001) :
                   ptr_r;
  // Pointer wraps across the 2 Mbyte range
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ptr_r <= PTR_RST;
    else ptr_r <= ptr_nxt;
  end
  assign port.value = ptr_r;
endmodule // ptr_unit

// >>> exec_core_properties.sv
`timescale 1ns/1ns
module exec_core_props
  import exec_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic        next_two_word_in,
  input wire logic        ext_set_in,
  input wire logic [3:0]  bank_select_register_in,
  input wire logic [11:0] index_base_in,
  input wire logic [7:0]  table_data_latch_in,
  input wire logic [7:0]  file_data_in,
  input wire logic        busy_out,
  input wire logic        discard_out,
  input wire logic [11:0] file_addr_out,
  input wire logic [7:0]  holding_data_out,
  input wire logic        holding_write_out,
  input wire logic [7:0]  w_out,
  input wire logic        zero_flag_out
);
  // Accepted words by kind; a word offered while busy is not taken
  wire tw_go = instr_valid_in & ~busy_out & ((instr_in & TBLWR_MASK) == TBLWR_BASE);
  wire xor_go = instr_valid_in & ~busy_out & ((instr_in & XORL_MASK) == XORL_BASE);
  wire tst_go = instr_valid_in & ~busy_out & ((instr_in & TSTZ_MASK) == TSTZ_BASE);
  wire zero_go = tst_go & (file_data_in == 8'h00);
  wire idx_mode = ext_set_in & ~instr_in[ACC_BIT] & (instr_in[7:0] <= IDX_LIMIT);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_xor_value: assert property (xor_go |=> w_out == ($past(w_out) ^ $past(instr_in[7:0])))
    else $error("xor result wrong");
  a_xor_zero: assert property (xor_go |=> zero_flag_out == (w_out == 8'h00))
    else $error("xor zero flag wrong");
  a_tw_timing: assert property (tw_go |=> busy_out && !holding_write_out ##1
    holding_write_out && !busy_out) else $error("table write timing wrong");
  a_tw_data: assert property (tw_go |-> ##2 holding_data_out == $past(table_data_latch_in))
    else $error("holding data wrong");
  a_skip_one: assert property (zero_go && !next_two_word_in |=> discard_out ##1
    !discard_out && !busy_out) else $error("one word skip wrong");
  a_skip_two: assert property (zero_go && next_two_word_in |=> discard_out [*2] ##1
    !busy_out) else $error("two word skip wrong");
  a_no_skip: assert property (tst_go && !zero_go |=> !discard_out && !busy_out)
    else $error("skip without zero");
  a_bank_sel: assert property (tst_go && instr_in[ACC_BIT] |->
    file_addr_out == {bank_select_register_in, instr_in[7:0]}) else $error("banked address wrong");
  a_acc_bank: assert property (tst_go && !instr_in[ACC_BIT] && !idx_mode |->
    file_addr_out == {(instr_in[7:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, instr_in[7:0]})
    else $error("access bank address wrong");
  a_indexed: assert property (tst_go && idx_mode |->
    file_addr_out == index_base_in + {4'h0, instr_in[7:0]}) else $error("indexed address wrong");
endmodule // exec_core_props
bind exec_core exec_core_props props (.*);

// >>> data_mem_model.sv
`timescale 1ns/1ns
module data_mem_model (
  input  wire logic [11:0] addr_in,
  input  wire logic        read_in,
  output logic      [7:0]  data_out
);
  // Cells with a zero low nibble read zero; an idle read gives the inverse, never stale data
  assign data_out = read_in ? {2{addr_in[3:0]}} : ~{2{addr_in[3:0]}};
endmodule // data_mem_model

// >>> table_write_test_xor_exec_test.sv
`timescale 1ns/1ns
module table_write_test_xor_exec_test;
  import exec_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, instr_valid_in = 1'b0, next_two_word_in = 1'b0;
  logic ext_set_in = 1'b0, ptr_load_in = 1'b0, w_load_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [3:0]  bank_select_register_in = 4'h0;
  logic [11:0] index_base_in = 12'h123, file_addr_out, addr_seen;
  logic [7:0]  table_data_latch_in = 8'h00, file_data_in, w_load_val_in = 8'hB5;
  logic [20:0] ptr_load_val_in = 21'h00_A356, program_byte_pointer_out, holding_addr_out;
  logic [7:0]  holding_data_out, w_out;
  logic        busy_out, discard_out, file_read_out, holding_write_out;
  logic        neg_flag_out, zero_flag_out;
  logic        read_seen;
  int          mismatches = 0, num_checks = 0, disc;
  exec_core dut (.*);
  data_mem_model mem (.addr_in(file_addr_out), .read_in(file_read_out), .data_out(file_data_in));
  // Free running clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Offer one word for one cycle; the address is caught while the word is being taken
  task automatic issue(input logic [15:0] word);
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= word;
    @(negedge clk_in);
    addr_seen = file_addr_out;
    read_seen = file_read_out;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
  endtask
  task automatic t_xor(input logic [7:0] lit, input logic [7:0] exp_w);
    issue({8'h0A, lit});
    @(negedge clk_in);
    check({neg_flag_out, zero_flag_out, w_out}, {exp_w[7], exp_w == 8'h00, exp_w});
    $display("xor %h done", lit);
  endtask
  task automatic t_tw(input logic [1:0] mode, input logic [20:0] exp_a, input logic [20:0] exp_p);
    @(posedge clk_in);
    ptr_load_in <= 1'b1;
    table_data_latch_in <= {6'h15, mode};
    @(posedge clk_in);
    ptr_load_in <= 1'b0;
    issue({14'h0003, mode});
    @(negedge clk_in);
    check({busy_out, holding_write_out}, 2'b10);
    @(negedge clk_in);
    check({busy_out, holding_write_out, holding_data_out}, {2'b01, 6'h15, mode});
    check({holding_addr_out, program_byte_pointer_out}, {exp_a, exp_p});
    $display("table write mode %0d done", mode);
  endtask
  task automatic t_skip(input logic a, input logic ext, input logic [7:0] f, input logic two,
                        input logic [11:0] exp_a, input int exp_d);
    @(posedge clk_in);
    ext_set_in <= ext;
    bank_select_register_in <= f[3:0] ^ 4'h6;
    next_two_word_in <= two;
    issue({7'h33, a, f});
    disc = 0;
    repeat (3) begin
      @(negedge clk_in);
      if (discard_out === 1'b1) disc++;
    end
    check({read_seen, addr_seen, disc}, {1'b1, exp_a, exp_d});
    $display("skip test on %h done", f);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // W is preloaded once with a known value before the xor tests
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    w_load_in <= 1'b1;
    @(posedge clk_in);
    w_load_in <= 1'b0;
    t_xor(8'hAF, 8'h1A);
    t_xor(8'h1A, 8'h00);
    t_xor(8'h80, 8'h80);
    t_tw(2'h0, 21'h00_A356, 21'h00_A356);
    t_tw(2'h1, 21'h00_A356, 21'h00_A357);
    t_tw(2'h2, 21'h00_A356, 21'h00_A355);
    t_tw(2'h3, 21'h00_A357, 21'h00_A357);
    t_skip(1'b1, 1'b0, 8'h40, 1'b0, 12'h640, 1);
    t_skip(1'b1, 1'b1, 8'h41, 1'b1, 12'h741, 0);
    t_skip(1'b0, 1'b0, 8'h20, 1'b1, 12'h020, 2);
    t_skip(1'b0, 1'b0, 8'h90, 1'b0, 12'hF90, 1);
    t_skip(1'b0, 1'b1, 8'h5F, 1'b0, 12'h182, 0);
    t_skip(1'b0, 1'b1, 8'h0D, 1'b0, 12'h130, 1);
    t_skip(1'b0, 1'b1, 8'h60, 1'b0, 12'h060, 1);
    complete_run();
  end
endmodule // table_write_test_xor_exec_test
